// ===== rbw_pkg.sv
package rbw_pkg;
  // Request and response codes
  localparam logic [7:0] CMD_WRITE = 8'h08;
  localparam logic [7:0] RSP_WRITE = 8'h09;
  localparam logic [3:0] ID_LAST = 4'h7;
  // Field ranges
  localparam logic [7:0] SVC_MIN = 8'h01;
  localparam logic [7:0] SVC_MAX = 8'h0B;
  localparam logic [3:0] SVC_SPLIT = 4'h8;
  localparam logic [7:0] BLK_LIM_FEW = 8'h0C;
  localparam logic [7:0] BLK_LIM_MANY = 8'h0B;
  localparam logic [15:0] BLK_NUM_MAX = 16'h001F;
  localparam logic [3:0] BYTE_LAST = 4'hF;
  // Memory map
  localparam logic [4:0] AIB_BLOCK = 5'h00;
  localparam logic [4:0] MSG_FIRST = 5'h01;
  localparam logic [4:0] MSG_LAST = 5'h1A;
  localparam logic [8:0] SYS_CODE_ADDR = 9'h1E0;
  localparam logic [15:0] SYS_CODE_NDEF = 16'h12FC;
  // Status flags
  localparam logic [7:0] FLAG1_OK = 8'h00;
  localparam logic [7:0] FLAG1_ERR = 8'hFF;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_SVC_CNT = 8'hA1;
  localparam logic [7:0] ERR_SVC_MIS = 8'hA2;
  localparam logic [7:0] ERR_BLK_CNT = 8'hA3;
  localparam logic [7:0] ERR_BLK_NUM = 8'hA4;
  localparam logic [7:0] ERR_LEN = 8'hA5;
  // Bytes of the response after its code
  localparam logic [3:0] RESP_TAIL = 4'hA;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  typedef enum logic [10:0] {
    S_IDLE = 11'h001,
    S_ID = 11'h002,
    S_SVCN = 11'h004,
    S_SVC = 11'h008,
    S_BLKN = 11'h010,
    S_BLST = 11'h020,
    S_DATA = 11'h040,
    S_DONE = 11'h080,
    S_DRAIN = 11'h100,
    S_RESP = 11'h200,
    S_SKIP = 11'h400
  } rbw_state_e;
endpackage

// ===== rbw_mem_if.sv
`timescale 1ns/1ns
interface rbw_mem_if;
  logic wr;
  logic [8:0] addr;
  logic [7:0] data;
  logic ndefReady;
  modport ctrl (output wr, output addr, output data, input ndefReady);
  modport mem (input wr, input addr, input data, output ndefReady);
endinterface

// ===== rbw_nvm.sv
`timescale 1ns/1ns
module rbw_nvm #(
  parameter int ADDR_W = 9
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Write port from the interpreter
  rbw_mem_if.mem port
);
  typedef struct packed {
    logic [7:0] sysHi;
    logic [7:0] sysLo;
    logic ndefReady;
  } rbw_nvm_s;

  rbw_nvm_s r;
  rbw_nvm_s n;
  // Nonvolatile store is not cleared by reset
  logic [7:0] mem [2**ADDR_W];

  // Shadow of the system code so readiness is defined from reset on
  always_comb
  begin
    n = r;
    if (ce)
    begin
      if (port.wr && port.addr == rbw_pkg::SYS_CODE_ADDR)
        n.sysHi = port.data;
      if (port.wr && port.addr == rbw_pkg::SYS_CODE_ADDR + 9'h001)
        n.sysLo = port.data;
      n.ndefReady = ({r.sysHi, r.sysLo} == rbw_pkg::SYS_CODE_NDEF);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

  // Byte array write
  always_ff @(posedge sys_clk)
  begin
    if (ce && port.wr)
      mem[port.addr] <= port.data;
  end

  assign port.ndefReady = r.ndefReady;

  default clocking cb @(posedge sys_clk iff ce);
  endclocking
  default disable iff (rst);

  property p_sys_set;
    port.wr && port.addr == rbw_pkg::SYS_CODE_ADDR + 9'h001 &&
      port.data == 8'hFC && r.sysHi == 8'h12 |=> ##1 port.ndefReady;
  endproperty
  a_sys_set: assert property (p_sys_set)
    else $error("system code written but not ready");

  property p_sys_clear;
    port.wr && port.addr == rbw_pkg::SYS_CODE_ADDR && port.data != 8'h12
      |=> ##1 !port.ndefReady;
  endproperty
  a_sys_clear: assert property (p_sys_clear)
    else $error("ready kept after system code broken");

  c_ready: cover property ($rose(port.ndefReady));
endmodule

// ===== rbw_write_ctrl.sv
`timescale 1ns/1ns
module rbw_write_ctrl #(
  parameter int MAX_BLOCKS = 12
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Request bytes from the RF framer
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic rxEnd,
  // Own card id, first byte in the top bits
  input wire logic [63:0] cardId,
  // Tunnel mode strap pin
  input wire logic tunnelPin,
  // Response bytes to the RF framer
  output logic txValid,
  output logic [7:0] txByte,
  input wire logic txReady,
  // Tunnel data to the host
  output logic hostValid,
  output logic [7:0] hostByte,
  // Status
  output logic msgWrite,
  output logic ndefReady
);
  typedef struct packed {
    rbw_pkg::rbw_state_e st;
    logic [3:0] cnt;
    logic [3:0] svcN;
    logic [3:0] blkN;
    logic [3:0] idx;
    logic [15:0] svcFirst;
    logic [7:0] hold;
    logic [1:0] elemPos;
    logic elemLong;
    logic [MAX_BLOCKS-1:0][4:0] blkList;
    logic idOk;
    logic err;
    logic [7:0] errCode;
    logic [79:0] respSh;
    logic [3:0] respLeft;
    logic txValid;
    logic [7:0] txByte;
    logic hostValid;
    logic [7:0] hostByte;
    logic memWr;
    logic [8:0] memAddr;
    logic [7:0] memData;
    logic msgWrite;
    logic [2:0] tunSync;
    logic tunnel;
    logic ndefReady;
  } rbw_ctrl_s;

  rbw_ctrl_s r;
  rbw_ctrl_s n;
  logic [4:0] curBlk;
  logic take;
  rbw_mem_if mif ();

  assign curBlk = r.blkList[r.idx];
  // Bytes that share a cycle with the frame end are not part of it
  assign take = rxValid && !rxEnd;

  rbw_nvm #(.ADDR_W(9)) u_nvm (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .port(mif.mem)
  );

  // Parser, checker and responder
  always_comb
  begin
    logic [15:0] word;
    logic [7:0] lim;
    logic [7:0] code;
    word = '0;
    lim = '0;
    code = '0;
    n = r;
    if (ce)
    begin
      n.memWr = 1'b0;
      n.hostValid = 1'b0;
      n.msgWrite = 1'b0;
      n.ndefReady = mif.ndefReady;
      // Three-stage sync; a change counts once stages two and three agree
      n.tunSync = {r.tunSync[1:0], tunnelPin};
      if (r.tunSync[1] == r.tunSync[2])
        n.tunnel = r.tunSync[2];
      if (rxEnd && r.st != rbw_pkg::S_RESP)
      begin
        // Frame closed: answer only when the card id was ours
        code = r.errCode;
        if (r.st != rbw_pkg::S_DONE && r.st != rbw_pkg::S_DRAIN && !r.err)
          code = rbw_pkg::ERR_LEN;
        if (r.st == rbw_pkg::S_IDLE || r.st == rbw_pkg::S_SKIP || !r.idOk)
          n.st = rbw_pkg::S_IDLE;
        else
        begin
          n.st = rbw_pkg::S_RESP;
          n.txValid = 1'b1;
          n.txByte = rbw_pkg::RSP_WRITE;
          n.respSh = {cardId,
            (code == rbw_pkg::ERR_NONE) ? rbw_pkg::FLAG1_OK
                                        : rbw_pkg::FLAG1_ERR,
            code};
          n.respLeft = rbw_pkg::RESP_TAIL;
        end
      end
      else
      begin
        case (r.st)
          rbw_pkg::S_IDLE:
          begin
            if (take && rxByte == rbw_pkg::CMD_WRITE)
            begin
              n.st = rbw_pkg::S_ID;
              n.cnt = '0;
              n.err = 1'b0;
              n.errCode = rbw_pkg::ERR_NONE;
              n.idOk = 1'b1;
            end
            else if (take)
              n.st = rbw_pkg::S_SKIP;
          end
          rbw_pkg::S_ID:
          begin
            if (take)
            begin
              // A foreign id makes the frame silent, not an error
              if (rxByte != cardId[{3'(rbw_pkg::ID_LAST[2:0] - r.cnt[2:0]),
                                    3'h0} +: 8])
                n.idOk = 1'b0;
              n.cnt = r.cnt + 4'h1;
              // A foreign frame is skipped whole, so none of it is stored
              if (r.cnt == rbw_pkg::ID_LAST)
                n.st = n.idOk ? rbw_pkg::S_SVCN : rbw_pkg::S_SKIP;
            end
          end
          rbw_pkg::S_SVCN:
          begin
            if (take)
            begin
              if (rxByte < rbw_pkg::SVC_MIN || rxByte > rbw_pkg::SVC_MAX)
              begin
                n.err = 1'b1;
                n.errCode = rbw_pkg::ERR_SVC_CNT;
                n.st = rbw_pkg::S_DRAIN;
              end
              else
              begin
                n.svcN = rxByte[3:0];
                n.cnt = '0;
                n.idx = '0;
                n.st = rbw_pkg::S_SVC;
              end
            end
          end
          rbw_pkg::S_SVC:
          begin
            if (take)
            begin
              n.cnt = r.cnt ^ 4'h1;
              if (!r.cnt[0])
                n.hold = rxByte;
              else
              begin
                word = {r.hold, rxByte};
                n.idx = r.idx + 4'h1;
                if (r.idx == '0)
                  n.svcFirst = word;
                if (r.idx != '0 && word != r.svcFirst)
                begin
                  n.err = 1'b1;
                  n.errCode = rbw_pkg::ERR_SVC_MIS;
                  n.st = rbw_pkg::S_DRAIN;
                end
                else if (r.idx == r.svcN - 4'h1)
                  n.st = rbw_pkg::S_BLKN;
              end
            end
          end
          rbw_pkg::S_BLKN:
          begin
            lim = (r.svcN <= rbw_pkg::SVC_SPLIT) ? rbw_pkg::BLK_LIM_FEW
                                                 : rbw_pkg::BLK_LIM_MANY;
            if (take)
            begin
              if (rxByte == 8'h00 || rxByte > lim)
              begin
                n.err = 1'b1;
                n.errCode = rbw_pkg::ERR_BLK_CNT;
                n.st = rbw_pkg::S_DRAIN;
              end
              else
              begin
                n.blkN = rxByte[3:0];
                n.idx = '0;
                n.elemPos = 2'h0;
                n.st = rbw_pkg::S_BLST;
              end
            end
          end
          rbw_pkg::S_BLST:
          begin
            if (take)
            begin
              // Bit 7 of the lead byte set means a two-byte element
              if (r.elemPos == 2'h0)
              begin
                n.elemLong = ~rxByte[7];
                n.elemPos = 2'h1;
              end
              else if (r.elemPos == 2'h1 && r.elemLong)
              begin
                n.hold = rxByte;
                n.elemPos = 2'h2;
              end
              else
              begin
                word = (r.elemPos == 2'h1) ? {8'h00, rxByte}
                                           : {rxByte, r.hold};
                n.elemPos = 2'h0;
                n.idx = r.idx + 4'h1;
                n.blkList[r.idx] = word[4:0];
                // All blocks are checked before any data byte lands
                if (word > rbw_pkg::BLK_NUM_MAX)
                begin
                  n.err = 1'b1;
                  n.errCode = rbw_pkg::ERR_BLK_NUM;
                  n.st = rbw_pkg::S_DRAIN;
                end
                else if (r.idx == r.blkN - 4'h1)
                begin
                  n.idx = '0;
                  n.cnt = '0;
                  n.st = rbw_pkg::S_DATA;
                end
              end
            end
          end
          rbw_pkg::S_DATA:
          begin
            if (take)
            begin
              if (r.tunnel)
              begin
                n.hostValid = 1'b1;
                n.hostByte = rxByte;
              end
              else
              begin
                n.memWr = 1'b1;
                n.memAddr = {curBlk, r.cnt};
                n.memData = rxByte;
                n.msgWrite = (curBlk >= rbw_pkg::MSG_FIRST &&
                              curBlk <= rbw_pkg::MSG_LAST);
              end
              n.cnt = r.cnt + 4'h1;
              if (r.cnt == rbw_pkg::BYTE_LAST)
              begin
                n.idx = r.idx + 4'h1;
                if (r.idx == r.blkN - 4'h1)
                  n.st = rbw_pkg::S_DONE;
              end
            end
          end
          rbw_pkg::S_DONE:
          begin
            // Surplus bytes: blocks are already stored or sent to the host, only the flag tells
            if (take)
            begin
              n.err = 1'b1;
              n.errCode = rbw_pkg::ERR_LEN;
              n.st = rbw_pkg::S_DRAIN;
            end
          end
          rbw_pkg::S_DRAIN:
            n.st = r.st;
          rbw_pkg::S_RESP:
          begin
            if (r.txValid && txReady)
            begin
              if (r.respLeft == '0)
              begin
                n.txValid = 1'b0;
                n.st = rbw_pkg::S_IDLE;
              end
              else
              begin
                n.txByte = r.respSh[79:72];
                n.respSh = {r.respSh[71:0], 8'h00};
                n.respLeft = r.respLeft - 4'h1;
              end
            end
          end
          rbw_pkg::S_SKIP:
            n.st = r.st;
          default:
            n.st = rbw_pkg::S_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.st <= rbw_pkg::S_IDLE;
      r.tunSync <= rbw_pkg::SYNC_RESET;
    end
    else
      r <= n;
  end

  // Outputs and memory port
  assign mif.wr = r.memWr;
  assign mif.addr = r.memAddr;
  assign mif.data = r.memData;
  assign txValid = r.txValid;
  assign txByte = r.txByte;
  assign hostValid = r.hostValid;
  assign hostByte = r.hostByte;
  assign msgWrite = r.msgWrite;
  assign ndefReady = r.ndefReady;

  default clocking cb @(posedge sys_clk iff ce);
  endclocking
  default disable iff (rst);

  property p_cmd;
    r.st == rbw_pkg::S_IDLE && take && rxByte == rbw_pkg::CMD_WRITE
      |=> r.st == rbw_pkg::S_ID && r.cnt == 4'h0;
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("write code not followed by the id field");

  // Counted in taken bytes, so gaps between bytes do not matter
  property p_id_len;
    r.st == rbw_pkg::S_ID && take
      |=> (r.st == rbw_pkg::S_ID) == ($past(r.cnt) != rbw_pkg::ID_LAST);
  endproperty
  a_id_len: assert property (p_id_len)
    else $error("card id field not exactly 8 bytes");

  property p_svc_range;
    r.st == rbw_pkg::S_SVCN && take && (rxByte == 8'h00 || rxByte > 8'h0B)
      |=> r.err && r.errCode == rbw_pkg::ERR_SVC_CNT;
  endproperty
  a_svc_range: assert property (p_svc_range)
    else $error("bad service count accepted");

  property p_svc_mis;
    r.st == rbw_pkg::S_SVC && take && r.cnt[0] && r.idx != '0 &&
      {r.hold, rxByte} != r.svcFirst |=> r.err;
  endproperty
  a_svc_mis: assert property (p_svc_mis)
    else $error("differing service ids accepted");

  property p_blk_range;
    r.st == rbw_pkg::S_BLKN && take && (rxByte == 8'h00 ||
      rxByte > ((r.svcN <= 4'h8) ? 8'h0C : 8'h0B))
      |=> r.errCode == rbw_pkg::ERR_BLK_CNT && r.st == rbw_pkg::S_DRAIN;
  endproperty
  a_blk_range: assert property (p_blk_range)
    else $error("bad block count accepted");

  property p_tunnel;
    r.st == rbw_pkg::S_DATA && take && r.tunnel
      |=> r.hostValid && !r.memWr && r.hostByte == $past(rxByte);
  endproperty
  a_tunnel: assert property (p_tunnel)
    else $error("tunnel byte not forwarded");

  property p_wr_addr;
    r.st == rbw_pkg::S_DATA && take && !r.tunnel
      |=> r.memWr && r.memAddr == {$past(curBlk), $past(r.cnt)};
  endproperty
  a_wr_addr: assert property (p_wr_addr)
    else $error("block data at wrong address");

  property p_aib;
    r.memWr && r.memAddr[8:4] == rbw_pkg::AIB_BLOCK |-> !r.msgWrite;
  endproperty
  a_aib: assert property (p_aib)
    else $error("attribute block counted as message");

  property p_no_wr_err;
    r.err |=> !r.memWr;
  endproperty
  a_no_wr_err: assert property (p_no_wr_err)
    else $error("memory written after a failed check");

  property p_resp_code;
    $rose(r.txValid) |-> r.txByte == rbw_pkg::RSP_WRITE &&
      r.respLeft == 4'hA;
  endproperty
  a_resp_code: assert property (p_resp_code)
    else $error("response does not open with its code");

  property p_resp_hold;
    r.txValid && !txReady |=> r.txValid && $stable(r.txByte);
  endproperty
  a_resp_hold: assert property (p_resp_hold)
    else $error("response byte dropped while stalled");

  c_resp: cover property (r.st == rbw_pkg::S_RESP && r.respLeft == '0 &&
    txReady && r.errCode == rbw_pkg::ERR_NONE);
  c_err: cover property (r.st == rbw_pkg::S_RESP && r.err);
  c_host: cover property (r.hostValid);
  c_msg: cover property (r.msgWrite);
endmodule

// ===== rbw_reader.sv
`timescale 1ns/1ns
module rbw_reader (
  // Clock
  input wire logic sys_clk,
  // Request side
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic rxEnd,
  // Response side
  input wire logic txValid,
  output logic txReady
);
  logic [7:0] frame [$];
  int stallPct = 0;
  int gapMax = 0;
  int seed = 26;

  // Quiet lines at time zero
  initial
  begin
    rxValid = 1'b0;
    rxByte = 8'h00;
    rxEnd = 1'b0;
  end

  // Random stalls show that the response holds until taken
  always @(negedge sys_clk)
    txReady <= ({$random(seed)} % 100) >= stallPct;

  // One request: bytes in order, optional gaps, then the end pulse
  task automatic send_frame();
    int g;
    begin
      foreach (frame[i])
      begin
        @(negedge sys_clk);
        rxValid = 1'b1;
        rxByte = frame[i];
        g = {$random(seed)} % (gapMax + 1);
        // Idle bytes toggle so a stale value is never mistaken for data
        repeat (g)
        begin
          @(negedge sys_clk);
          rxValid = 1'b0;
          rxByte = ~rxByte;
        end
      end
      @(negedge sys_clk);
      rxValid = 1'b0;
      rxByte = ~rxByte;
      rxEnd = 1'b1;
      @(negedge sys_clk);
      rxEnd = 1'b0;
      rxByte = ~rxByte;
    end
  endtask
endmodule

// ===== test_rf_block_write_ndef_map.sv
`timescale 1ns/1ns
module test_rf_block_write_ndef_map;
  logic sys_clk;
  logic rst;
  logic ce;
  logic rxValid;
  logic [7:0] rxByte;
  logic rxEnd;
  logic [63:0] cardId;
  logic tunnelPin;
  logic txValid;
  logic [7:0] txByte;
  logic txReady;
  logic hostValid;
  logic [7:0] hostByte;
  logic msgWrite;
  logic ndefReady;
  logic [7:0] expQ [$];
  logic [7:0] hostQ [$];
  logic [7:0] want;
  logic [63:0] idUse;
  logic [15:0] sysWord;
  int err_count = 0;
  int cmp_count = 0;
  int wrCount = 0;
  int seed = 26;
  int r;
  int k;
  int m;
  int b;

  // Clock at 25 MHz
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  rbw_write_ctrl #(.MAX_BLOCKS(12)) DUT (
    .sys_clk(sys_clk), .rst(rst), .ce(ce),
    .rxValid(rxValid), .rxByte(rxByte), .rxEnd(rxEnd),
    .cardId(cardId), .tunnelPin(tunnelPin),
    .txValid(txValid), .txByte(txByte), .txReady(txReady),
    .hostValid(hostValid), .hostByte(hostByte),
    .msgWrite(msgWrite), .ndefReady(ndefReady)
  );

  rbw_reader rdr (
    .sys_clk(sys_clk), .rxValid(rxValid), .rxByte(rxByte), .rxEnd(rxEnd),
    .txValid(txValid), .txReady(txReady)
  );

  task automatic close_out();
    begin
      if (err_count == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      cmp_count++;
      if (seen !== exp)
      begin
        err_count++;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // Builds one request, notes the expected answer, sends it, waits
  task automatic do_write(input int k, input int m, input int blk,
    input bit three, input bit mis, input logic [7:0] code,
    input logic [7:0] err, input int expWr, input bit tun);
    int i;
    logic [15:0] svc;
    logic [7:0] d;
    bit ans;
    begin
      // A frozen block answers nothing
      ans = (code == rbw_pkg::CMD_WRITE) && (idUse === cardId) && ce;
      svc = 16'($random(seed));
      wrCount = 0;
      rdr.frame.delete();
      rdr.frame.push_back(code);
      for (i = 7; i >= 0; i--)
        rdr.frame.push_back(idUse[i*8 +: 8]);
      rdr.frame.push_back(8'(k));
      for (i = 0; i < k; i++)
      begin
        if (mis && i == k - 1)
          svc = ~svc;
        rdr.frame.push_back(svc[15:8]);
        rdr.frame.push_back(svc[7:0]);
      end
      rdr.frame.push_back(8'(m));
      for (i = 0; i < m; i++)
      begin
        rdr.frame.push_back(three ? 8'h00 : 8'h80);
        rdr.frame.push_back(8'(blk + i));
        if (three)
          rdr.frame.push_back(8'h00);
      end
      for (i = 0; i < 16 * m; i++)
      begin
        d = 8'($random(seed));
        if (blk == 30 && i < 2)
          d = (i == 1) ? sysWord[7:0] : sysWord[15:8];
        rdr.frame.push_back(d);
        if (tun && ans && err == rbw_pkg::ERR_NONE)
          hostQ.push_back(d);
      end
      if (ans)
      begin
        expQ.push_back(rbw_pkg::RSP_WRITE);
        for (i = 7; i >= 0; i--)
          expQ.push_back(cardId[i*8 +: 8]);
        if (err == rbw_pkg::ERR_NONE)
          expQ.push_back(rbw_pkg::FLAG1_OK);
        else
          expQ.push_back(rbw_pkg::FLAG1_ERR);
        expQ.push_back(err);
      end
      rdr.send_frame();
      for (i = 0; i < 4000 && (expQ.size() != 0 || txValid !== 1'b0); i++)
        @(posedge sys_clk);
      if (i == 4000)
      begin
        err_count++;
        close_out();
      end
      // Settle time lets any stray answer or pulse show up
      repeat (8) @(posedge sys_clk);
      check(wrCount, expWr);
      check(hostQ.size(), 0);
    end
  endtask

  // Answer and tunnel bytes are matched as they appear, write pulses are counted
  always @(posedge sys_clk)
  begin
    if (rst === 1'b0)
    begin
      if (txValid === 1'b1 && txReady === 1'b1)
      begin
        want = (expQ.size() != 0) ? expQ.pop_front() : 8'hXX;
        check(txByte, want);
      end
      if (hostValid === 1'b1)
      begin
        want = (hostQ.size() != 0) ? hostQ.pop_front() : 8'hXX;
        check(hostByte, want);
      end
      if (msgWrite === 1'b1)
        wrCount++;
    end
  end

  // Main sequence
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    tunnelPin = 1'b0;
    cardId = {$random(seed), $random(seed)};
    idUse = cardId;
    sysWord = 16'h0000;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    check(ndefReady, 1'b0);
    check(txValid, 1'b0);
    do_write(1, 1, 5, 0, 0, 8'h08, 8'h00, 16, 0);
    do_write(1, 1, 26, 1, 0, 8'h08, 8'h00, 16, 0);
    do_write(1, 1, 0, 0, 0, 8'h08, 8'h00, 0, 0);
    do_write(1, 1, 27, 1, 0, 8'h08, 8'h00, 0, 0);
    do_write(8, 12, 1, 0, 0, 8'h08, 8'h00, 192, 0);
    do_write(11, 11, 10, 1, 0, 8'h08, 8'h00, 176, 0);
    do_write(9, 12, 1, 0, 0, 8'h08, 8'hA3, 0, 0);
    do_write(1, 13, 1, 0, 0, 8'h08, 8'hA3, 0, 0);
    do_write(1, 0, 1, 0, 0, 8'h08, 8'hA3, 0, 0);
    do_write(0, 1, 1, 0, 0, 8'h08, 8'hA1, 0, 0);
    do_write(12, 1, 1, 0, 0, 8'h08, 8'hA1, 0, 0);
    do_write(3, 1, 2, 0, 1, 8'h08, 8'hA2, 0, 0);
    do_write(2, 1, 2, 1, 0, 8'h08, 8'h00, 16, 0);
    rdr.stallPct = 40;
    rdr.gapMax = 2;
    @(negedge sys_clk);
    tunnelPin = 1'b1;
    repeat (4) @(negedge sys_clk);
    do_write(2, 2, 3, 0, 0, 8'h08, 8'h00, 0, 1);
    do_write(0, 1, 3, 0, 0, 8'h08, 8'hA1, 0, 1);
    @(negedge sys_clk);
    tunnelPin = 1'b0;
    repeat (4) @(negedge sys_clk);
    // Frozen block: a whole frame passes unseen while the enable is low
    ce = 1'b0;
    do_write(1, 1, 6, 0, 0, 8'h08, 8'h00, 0, 0);
    @(negedge sys_clk);
    ce = 1'b1;
    idUse = ~cardId;
    do_write(1, 1, 4, 0, 0, 8'h08, 8'h00, 0, 0);
    idUse = cardId;
    do_write(1, 1, 4, 0, 0, 8'h06, 8'h00, 0, 0);
    sysWord = 16'h12FD;
    do_write(1, 1, 30, 0, 0, 8'h08, 8'h00, 0, 0);
    check(ndefReady, 1'b0);
    sysWord = rbw_pkg::SYS_CODE_NDEF;
    do_write(1, 1, 30, 1, 0, 8'h08, 8'h00, 0, 0);
    check(ndefReady, 1'b1);
    // Breaking the high byte must drop readiness again
    sysWord = 16'h02FC;
    do_write(1, 1, 30, 0, 0, 8'h08, 8'h00, 0, 0);
    check(ndefReady, 1'b0);
    sysWord = rbw_pkg::SYS_CODE_NDEF;
    do_write(1, 1, 30, 1, 0, 8'h08, 8'h00, 0, 0);
    check(ndefReady, 1'b1);
    // Mid-run reset clears the shadow even though memory keeps its bytes
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    check(ndefReady, 1'b0);
    check(txValid, 1'b0);
    for (r = 0; r < 6; r++)
    begin
      k = 1 + {$random(seed)} % 11;
      m = 1 + {$random(seed)} % ((k > 8) ? 11 : 12);
      b = 1 + {$random(seed)} % (27 - m);
      do_write(k, m, b, r % 2, 0, 8'h08, 8'h00, 16 * m, 0);
    end
    close_out();
  end
endmodule
